// >>> rtl/cec_pkg.sv
// Constants, types and helpers shared by the comparator event control block
//
// Overview of operation
// - The comparator output level is one while the positive input is above the negative input, else zero.
// - The comparator output can trigger the timer capture function besides its own comparator interrupt.
// - Software chooses whether the comparator event is a rising edge, a falling edge or any toggle.
// - Setting control bit 7 switches the comparator power off, allowed at any time.
// - Control bit 6 is reserved, not writable and reads as zero.
// - Control bit 5 is read-only and shows the present comparator output level, not a latched copy.
// - The event flag at bit 4 is set when an output transition matches the selected event mode.
// - The comparator interrupt is requested only while flag, enable bit 3 and global enable are all one.
// - The event flag clears by itself when the processor runs the comparator interrupt vector.
// - Writing one to the flag position clears the flag, writing zero leaves it alone.
// - A read-modify-write of another bit writes back a set flag as one and so clears it.
// - With route bit 2 set the output feeds the timer capture front end, with it clear there is no path.
// - Mode bits 1:0 code 00 as toggle, 01 as reserved, 10 as falling edge and 11 as rising edge.
package cec_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  CEC_ADDR_CTL  = 8'h08;
  localparam logic [7:0]  CEC_ADDR_STAT = 8'h0C;
  localparam logic [7:0]  CEC_ADDR_MASK = 8'h10;

  // ----------------------------------------------------------------
  // Control and status register fields
  // ----------------------------------------------------------------
  localparam int unsigned CEC_BIT_POWER_OFF = 7;
  localparam int unsigned CEC_BIT_RSVD      = 6;
  localparam int unsigned CEC_BIT_LEVEL     = 5;
  localparam int unsigned CEC_BIT_FLAG      = 4;
  localparam int unsigned CEC_BIT_IRQ_EN    = 3;
  localparam int unsigned CEC_BIT_ROUTE     = 2;
  localparam int unsigned CEC_BIT_MODE_HI   = 1;
  localparam int unsigned CEC_BIT_MODE_LO   = 0;
  localparam logic [7:0]  CEC_CTL_RESET     = 8'h00;
  localparam logic [7:0]  CEC_CTL_WMASK     = 8'h8F;

  // ----------------------------------------------------------------
  // Event mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CEC_MODE_TOGGLE = 2'h0;
  localparam logic [1:0] CEC_MODE_RSVD   = 2'h1;
  localparam logic [1:0] CEC_MODE_FALL   = 2'h2;
  localparam logic [1:0] CEC_MODE_RISE   = 2'h3;

  // ----------------------------------------------------------------
  // Interrupt status and mask layout
  // ----------------------------------------------------------------
  localparam int unsigned CEC_STAT_W     = 2;
  localparam int unsigned CEC_STAT_MATCH = 0;
  localparam int unsigned CEC_STAT_EDGE  = 1;
  localparam logic [1:0]  CEC_STAT_RESET = 2'h0;
  localparam logic [1:0]  CEC_MASK_RESET = 2'h0;

  // Bus answer sequencer
  typedef enum logic [0:0] {
    CEC_BUS_IDLE,
    CEC_BUS_ACK
  } cec_bus_state_t;

  // Decide whether an output change matches the event mode
  function automatic logic cec_mode_match(input logic [1:0] mode, input logic rise, input logic fall);
    logic hit;
    hit = 1'b0;
    case (mode)
      CEC_MODE_TOGGLE: hit = rise | fall;
      CEC_MODE_FALL:   hit = fall;
      CEC_MODE_RISE:   hit = rise;
      default:         hit = 1'b0;
    endcase
    return hit;
  endfunction

endpackage

// >>> rtl/cec_sync.sv
// Two flip-flop level synchroniser with a constant reset value
`timescale 1ns/1ps
module cec_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic d_in,
  output logic      q_out
);
  import cec_pkg::*;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } cec_sync_state_t;

  cec_sync_state_t state_reg;
  cec_sync_state_t state_next;

  // Stage one is read by stage two only
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = d_in;
    state_next.stage2 = state_reg.stage1;
  end

  // Asynchronous reset to a constant
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= {RESET_VAL, RESET_VAL};
    end else begin
      state_reg <= state_next;
    end
  end

  assign q_out = state_reg.stage2;
endmodule

// >>> rtl/cec_edge.sv
// Edge detector and event mode matcher for the comparator level
`timescale 1ns/1ps
module cec_edge (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       level_in,
  input  wire logic [1:0] mode_in,
  output logic            match_out,
  output logic            edge_out
);
  import cec_pkg::*;

  typedef struct packed {
    logic prev;
  } cec_edge_state_t;

  cec_edge_state_t state_reg;
  cec_edge_state_t state_next;
  logic            rise;
  logic            fall;

  // Remember last level
  always_comb begin
    state_next      = state_reg;
    state_next.prev = level_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Edges of the synchronised level
  assign rise = level_in & ~state_reg.prev;
  assign fall = ~level_in & state_reg.prev;
  assign edge_out = rise | fall;
  assign match_out = cec_mode_match(mode_in, rise, fall);
endmodule

// >>> rtl/cec_top.sv
// Comparator event control: Avalon-MM registers, event flag, interrupts and capture route
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module cec_top (
  input  wire logic                      clk_in,
  input  wire logic                      rst_b_in,
  input  wire logic [cec_pkg::ADDR_W-1:0] avs_address_in,
  input  wire logic                      avs_read_in,
  input  wire logic                      avs_write_in,
  input  wire logic [31:0]               avs_writedata_in,
  input  wire logic [3:0]                avs_byteenable_in,
  output logic      [31:0]               avs_readdata_out,
  output logic                           avs_waitrequest_out,
  input  wire logic                      comparator_raw_in,
  output logic                           comparator_power_off_out,
  input  wire logic                      global_irq_enable_in,
  input  wire logic                      vector_ack_in,
  output logic                           capture_trigger_out,
  output logic                           comparator_irq_out,
  output logic                           irq_out
);
  import cec_pkg::*;

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    cec_bus_state_t       bus;
    logic [7:0]           ctl;
    logic                 flag;
    logic [CEC_STAT_W-1:0] stat;
    logic [CEC_STAT_W-1:0] mask;
    logic [CEC_STAT_W-1:0] rd_clear;
    logic [31:0]          rdata;
    logic                 capture;
  } cec_top_state_t;

  cec_top_state_t state_reg;
  cec_top_state_t state_next;

  logic       rst_b_sync;
  logic       raw_sync;
  logic       level;
  logic       match;
  logic       any_edge;
  logic       take;
  logic       wr_ack;
  logic       rd_ack;
  logic       wr_ctl;
  logic       flag_clear;
  logic [7:0] ctl_view;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------

  // Reset asserts at once and leaves two edges after the pin rises
  cec_sync #(
    .RESET_VAL (1'b0)
  ) u_rst_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (1'b1),
    .q_out    (rst_b_sync)
  );

  // ----------------------------------------------------------------
  // Comparator level path
  // ----------------------------------------------------------------

  cec_sync #(
    .RESET_VAL (1'b0)
  ) u_cmp_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_sync),
    .d_in     (comparator_raw_in),
    .q_out    (raw_sync)
  );

  // level means positive above negative
  // A powered-off comparator reads low; this can itself look like a falling edge
  assign level = raw_sync & ~state_reg.ctl[CEC_BIT_POWER_OFF];

  cec_edge u_edge (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_sync),
    .level_in  (level),
    .mode_in   (state_reg.ctl[CEC_BIT_MODE_HI:CEC_BIT_MODE_LO]),
    .match_out (match),
    .edge_out  (any_edge)
  );

  // ----------------------------------------------------------------
  // Register view
  // ----------------------------------------------------------------

  always_comb begin
    ctl_view                = state_reg.ctl & CEC_CTL_WMASK;
    ctl_view[CEC_BIT_RSVD]  = 1'b0;
    ctl_view[CEC_BIT_LEVEL] = level;
    ctl_view[CEC_BIT_FLAG]  = state_reg.flag;
  end

  // Bus strobes; a request is answered on its second edge
  assign take   = avs_read_in | avs_write_in;
  assign wr_ack = (state_reg.bus == CEC_BUS_ACK) & avs_write_in & avs_byteenable_in[0];
  assign rd_ack = (state_reg.bus == CEC_BUS_ACK) & avs_read_in;
  assign wr_ctl = wr_ack & (avs_address_in == CEC_ADDR_CTL);

  // flag clear sources
  // Any write of the control word with bit 4 set clears, so read-modify-write does too
  assign flag_clear = vector_ack_in | (wr_ctl & avs_writedata_in[CEC_BIT_FLAG]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // Bus sequencer; read data is prepared one edge before the answer
    case (state_reg.bus)
      CEC_BUS_IDLE: begin
        if (take) begin
          state_next.bus      = CEC_BUS_ACK;
          state_next.rd_clear = '0;
          state_next.rdata    = 32'h0000_0000;
          if (avs_read_in) begin
            case (avs_address_in)
              CEC_ADDR_CTL: begin
                state_next.rdata = {24'h00_0000, ctl_view};
              end
              CEC_ADDR_STAT: begin
                state_next.rdata    = {30'h0000_0000, state_reg.stat};
                state_next.rd_clear = state_reg.stat;
              end
              CEC_ADDR_MASK: begin
                state_next.rdata = {30'h0000_0000, state_reg.mask};
              end
              default: begin
                state_next.rdata = 32'h0000_0000;
              end
            endcase
          end
        end
      end
      CEC_BUS_ACK: begin
        state_next.bus = CEC_BUS_IDLE;
      end
      default: begin
        state_next.bus = CEC_BUS_IDLE;
      end
    endcase

    // power-off and other writable control bits
    if (wr_ctl) begin
      state_next.ctl = avs_writedata_in[7:0] & CEC_CTL_WMASK;
    end
    if (wr_ack && (avs_address_in == CEC_ADDR_MASK)) begin
      state_next.mask = avs_writedata_in[CEC_STAT_W-1:0];
    end

    // event sets flag, set beats clear
    state_next.flag = match | (state_reg.flag & ~flag_clear);

    // Sticky status; only bits the read returned are cleared, new events win
    state_next.stat = state_reg.stat & ~(rd_ack ? state_reg.rd_clear : '0);
    state_next.stat[CEC_STAT_MATCH] = state_next.stat[CEC_STAT_MATCH] | match;
    state_next.stat[CEC_STAT_EDGE]  = state_next.stat[CEC_STAT_EDGE] | any_edge;

    state_next.capture = state_reg.ctl[CEC_BIT_ROUTE] & level;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_sync) begin
    if (!rst_b_sync) begin
      state_reg          <= '0;
      state_reg.bus      <= CEC_BUS_IDLE;
      state_reg.ctl      <= CEC_CTL_RESET;
      state_reg.stat     <= CEC_STAT_RESET;
      state_reg.mask     <= CEC_MASK_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Waitrequest drops in the second cycle of every request
  assign avs_waitrequest_out = take & (state_reg.bus != CEC_BUS_ACK);
  assign avs_readdata_out    = state_reg.rdata;

  // power switch to the analog part
  assign comparator_power_off_out = state_reg.ctl[CEC_BIT_POWER_OFF];

  // capture feed, low while the route is off
  assign capture_trigger_out = state_reg.capture;

  assign comparator_irq_out = state_reg.flag & state_reg.ctl[CEC_BIT_IRQ_EN] & global_irq_enable_in;

  // Summary interrupt from masked sticky status
  assign irq_out = |(state_reg.stat & state_reg.mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  a_flag_on_event:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    match |=> state_reg.flag)
  else $error("event did not set the flag");

  a_write_one_clears:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (wr_ctl && avs_writedata_in[CEC_BIT_FLAG] && !match) |=> !state_reg.flag)
  else $error("write of one did not clear the flag");

  a_write_zero_keeps:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (wr_ctl && !avs_writedata_in[CEC_BIT_FLAG] && !vector_ack_in && state_reg.flag) |=> state_reg.flag)
  else $error("write of zero changed the flag");

  a_vector_clears:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (vector_ack_in && !match) |=> !state_reg.flag)
  else $error("vector did not clear the flag");

  a_irq_needs_all:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (state_reg.flag && !state_reg.ctl[CEC_BIT_IRQ_EN]) |-> !comparator_irq_out)
  else $error("interrupt without enable");

  a_irq_after_event:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (match && state_reg.ctl[CEC_BIT_IRQ_EN] && !wr_ctl) ##1 global_irq_enable_in |-> comparator_irq_out)
  else $error("enabled event gave no interrupt");

  a_reserved_reads_zero:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (rd_ack && avs_address_in == CEC_ADDR_CTL) |-> !avs_readdata_out[CEC_BIT_RSVD])
  else $error("reserved bit read as one");

  a_level_read_live:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (take && state_reg.bus == CEC_BUS_IDLE && avs_read_in && avs_address_in == CEC_ADDR_CTL)
      |=> avs_readdata_out[CEC_BIT_LEVEL] == $past(level))
  else $error("level bit not current");

  a_route_off_quiet:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    !state_reg.ctl[CEC_BIT_ROUTE] |=> !capture_trigger_out)
  else $error("capture fed while route off");

  a_route_follows:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (state_reg.ctl[CEC_BIT_ROUTE] && level) |=> capture_trigger_out)
  else $error("capture does not follow level");

  a_power_off_write:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (wr_ctl && avs_writedata_in[CEC_BIT_POWER_OFF]) |=> comparator_power_off_out && !level)
  else $error("power-off write not applied");

  a_reserved_mode:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (state_reg.ctl[CEC_BIT_MODE_HI:CEC_BIT_MODE_LO] == CEC_MODE_RSVD) |-> !match)
  else $error("event raised in reserved mode");

  a_rise_mode:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (state_reg.ctl[CEC_BIT_MODE_HI:CEC_BIT_MODE_LO] == CEC_MODE_RISE && match) |-> level && !$past(level))
  else $error("rising mode matched a non-rise");

  a_sync_delay:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (!state_reg.ctl[CEC_BIT_POWER_OFF] && comparator_raw_in) ##1 !state_reg.ctl[CEC_BIT_POWER_OFF]
      ##1 !state_reg.ctl[CEC_BIT_POWER_OFF] |-> level)
  else $error("level not through two stages");

  a_bus_one_wait:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (take && avs_waitrequest_out) |=> !avs_waitrequest_out)
  else $error("waitrequest held beyond one cycle");

  // Waitrequest is combinational, so a request is never answered in its
  // first cycle; a master that samples at the rising edge cannot miss
  // the single low cycle that follows
  a_wait_on_take:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (take && state_reg.bus == CEC_BUS_IDLE) |-> avs_waitrequest_out)
  else $error("request answered without a wait cycle");

  a_mask_write_lands:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (wr_ack && avs_address_in == CEC_ADDR_MASK) |=> state_reg.mask == $past(avs_writedata_in[CEC_STAT_W-1:0]))
  else $error("mask write not stored");

  a_status_read_clears:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (rd_ack && avs_address_in == CEC_ADDR_STAT && !match && !any_edge)
      |=> (state_reg.stat & $past(state_reg.rd_clear)) == '0)
  else $error("status read did not clear returned bits");

  a_edge_sticky:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    any_edge |=> state_reg.stat[CEC_STAT_EDGE])
  else $error("level change not recorded in status");

  a_match_sticky:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    match |=> state_reg.stat[CEC_STAT_MATCH])
  else $error("event not recorded in status");

  a_power_forces_low:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    comparator_power_off_out |-> !level)
  else $error("level seen while powered off");

  a_fall_mode:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (state_reg.ctl[CEC_BIT_MODE_HI:CEC_BIT_MODE_LO] == CEC_MODE_FALL && match) |-> !level && $past(level))
  else $error("falling mode matched a non-fall");

  a_toggle_mode:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    (state_reg.ctl[CEC_BIT_MODE_HI:CEC_BIT_MODE_LO] == CEC_MODE_TOGGLE && any_edge) |-> match)
  else $error("toggle mode missed a level change");

  // Bits outside the write mask must never be stored, although the register
  // view masks them again and forces the reserved bit to zero
  a_reserved_not_stored:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    wr_ctl |=> (state_reg.ctl & ~CEC_CTL_WMASK) == 8'h00)
  else $error("unwritable control bit stored");

  a_route_write:
  assert property (@(posedge clk_in) disable iff (!rst_b_sync)
    wr_ctl |=> state_reg.ctl[CEC_BIT_ROUTE] == $past(avs_writedata_in[CEC_BIT_ROUTE]))
  else $error("route bit write not stored");

endmodule

// >>> test/cec_far_model.sv
// Behavioural model of the analog comparator and the timer capture front end
`timescale 1ns/1ps
module cec_far_model (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [7:0] pos_in,
  input  wire logic [7:0] neg_in,
  input  wire logic       power_off_in,
  input  wire logic       trigger_in,
  input  wire logic       capture_irq_enable_in,
  output logic            raw_out,
  output logic [7:0]      capture_count_out,
  output logic            capture_irq_out
);
  logic wander_reg;
  logic trig_reg;
  logic cap_flag_reg;

  // level from inputs; unpowered output wanders so stale levels are not trusted
  assign raw_out = power_off_in ? wander_reg : (pos_in > neg_in);

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wander_reg <= 1'b0;
      trig_reg <= 1'b0;
      cap_flag_reg <= 1'b0;
      capture_count_out <= 8'h00;
    end else begin
      wander_reg <= !wander_reg;
      trig_reg <= trigger_in;
      if (trigger_in && !trig_reg) begin
        capture_count_out <= capture_count_out + 8'h01;
        cap_flag_reg <= 1'b1;
      end
    end
  end

  // capture interrupt needs its own enable
  assign capture_irq_out = cap_flag_reg & capture_irq_enable_in;
endmodule

// >>> test/tb.sv
// Self-checking bench for the comparator event control block
`timescale 1ns/1ps
module tb;
  import cec_pkg::*;
  logic        clk_in   = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  addr     = 8'h00;
  logic        rd       = 1'b0;
  logic        wr       = 1'b0;
  logic [31:0] wdata    = 32'h0;
  logic [3:0]  be       = 4'hF;
  logic        gie      = 1'b0;
  logic        vack     = 1'b0;
  logic        cap_en   = 1'b0;
  logic [7:0]  pos      = 8'h00;
  logic [7:0]  neg      = 8'h00;
  logic [31:0] seed     = 32'h947E9536;
  logic [31:0] rdata;
  logic        wait_req;
  logic        raw;
  logic        pwr_off;
  logic        cap_trig;
  logic        cmp_irq;
  logic        irq;
  logic [7:0]  cap_cnt;
  logic        cap_irq;
  int          fail_count = 0;
  int          cmp_count  = 0;
  int          cyc        = 0;

  cec_top u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req), .comparator_raw_in(raw), .comparator_power_off_out(pwr_off),
    .global_irq_enable_in(gie), .vector_ack_in(vack), .capture_trigger_out(cap_trig),
    .comparator_irq_out(cmp_irq), .irq_out(irq));

  cec_far_model u_far (.clk_in(clk_in), .rst_b_in(rst_b_in), .pos_in(pos), .neg_in(neg),
    .power_off_in(pwr_off), .trigger_in(cap_trig), .capture_irq_enable_in(cap_en), .raw_out(raw),
    .capture_count_out(cap_cnt), .capture_irq_out(cap_irq));

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    forever #12.5 clk_in = !clk_in;
  end

  // Cuts a hang short; the whole run needs a few hundred cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Holds the request until a rising edge at which waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] q);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    rd <= !w;
    wr <= w;
    // Values read just after the edge are the ones that edge sampled
    @(posedge clk_in);
    while (wait_req !== 1'b0) begin
      @(posedge clk_in);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] q;
    bus(1'b1, a, v, q);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask

  task automatic drive(input logic [7:0] p, input logic [7:0] n);
    pos <= p;
    neg <= n;
    repeat (6) @(posedge clk_in);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  // Expected event for a mode and a level change
  function automatic logic hit(input logic [1:0] m, input logic r, input logic f);
    return (m == CEC_MODE_TOGGLE) ? (r | f) : (m == CEC_MODE_FALL) ? f : (m == CEC_MODE_RISE) ? r : 1'b0;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0]  m;
    logic        rt;
    logic        l0;
    logic        l1;
    logic [7:0]  c0;
    logic [31:0] q;
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd_chk("ctl reset", CEC_ADDR_CTL, 32'h0);
    rd_chk("status reset", CEC_ADDR_STAT, 32'h0);
    rd_chk("mask reset", CEC_ADDR_MASK, 32'h0);
    // Interrupt enable stays off while the power bit changes
    wr_reg(CEC_ADDR_CTL, 32'hF7);
    rd_chk("ctl ones", CEC_ADDR_CTL, 32'h87);
    chk1("power off", 1'b1, pwr_off);
    wr_reg(CEC_ADDR_CTL, 32'h00);
    // The write lands on the edge the task returns at
    @(posedge clk_in);
    chk1("power on", 1'b0, pwr_off);
    // Random levels and modes, every sixth pass with equal inputs
    l0 = 1'b0;
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      m = seed[1:0];
      rt = seed[2];
      wr_reg(CEC_ADDR_CTL, {24'h0, 3'h0, 1'b1, 1'b0, rt, m});
      l1 = (i % 6 == 0) ? 1'b0 : (seed[15:8] > seed[23:16]);
      drive(seed[15:8], (i % 6 == 0) ? seed[15:8] : seed[23:16]);
      rd_chk("ctl event", CEC_ADDR_CTL, {26'h0, l1, hit(m, !l0 & l1, l0 & !l1), 1'b0, rt, m});
      chk1("capture path", rt & l1, cap_trig);
      l0 = l1;
    end
    // Flag write semantics and capture routing
    wr_reg(CEC_ADDR_CTL, 32'h13);
    drive(8'h00, 8'h00);
    drive(8'hFF, 8'h00);
    rd_chk("flag set", CEC_ADDR_CTL, 32'h33);
    chk1("capture irq off", 1'b0, cap_irq);
    c0 = cap_cnt;
    wr_reg(CEC_ADDR_CTL, 32'h07);
    rd_chk("flag kept", CEC_ADDR_CTL, 32'h37);
    chk("capture count", {24'h0, c0 + 8'h01}, {24'h0, cap_cnt});
    cap_en <= 1'b1;
    wr_reg(CEC_ADDR_CTL, 32'h13);
    rd_chk("flag cleared", CEC_ADDR_CTL, 32'h23);
    chk1("capture irq on", 1'b1, cap_irq);
    // Comparator interrupt gating and vector clear
    drive(8'h00, 8'h00);
    wr_reg(CEC_ADDR_CTL, 32'h1B);
    drive(8'hFF, 8'h00);
    chk1("irq no global", 1'b0, cmp_irq);
    gie <= 1'b1;
    @(posedge clk_in);
    chk1("irq global", 1'b1, cmp_irq);
    vack <= 1'b1;
    @(posedge clk_in);
    vack <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk1("irq after vector", 1'b0, cmp_irq);
    rd_chk("flag after vector", CEC_ADDR_CTL, 32'h2B);
    // Status, mask and the summary interrupt
    bus(1'b0, CEC_ADDR_STAT, 32'h0, q);
    wr_reg(CEC_ADDR_MASK, 32'h1);
    wr_reg(CEC_ADDR_CTL, 32'h10);
    drive(8'h00, 8'h00);
    chk1("irq out set", 1'b1, irq);
    rd_chk("status both", CEC_ADDR_STAT, 32'h3);
    @(posedge clk_in);
    chk1("irq out cleared", 1'b0, irq);
    wr_reg(CEC_ADDR_MASK, 32'h0);
    wr_reg(CEC_ADDR_CTL, 32'h11);
    drive(8'hFF, 8'h00);
    chk1("irq out masked", 1'b0, irq);
    rd_chk("status reserved mode", CEC_ADDR_STAT, 32'h2);
    // Refused accesses
    rd_chk("unmapped read", 8'h20, 32'h0);
    wr_reg(8'h20, 32'hFF);
    be <= 4'h0;
    wr_reg(CEC_ADDR_CTL, 32'h84);
    be <= 4'hF;
    rd_chk("no byte enable", CEC_ADDR_CTL, 32'h21);
    // Power off hides the live level
    wr_reg(CEC_ADDR_CTL, 32'h81);
    repeat (4) @(posedge clk_in);
    rd_chk("level while off", CEC_ADDR_CTL, 32'h81);
    chk1("power off out", 1'b1, pwr_off);
    test_done();
  end
endmodule
